//--- common/lcd_cmd_pkg.sv
// Purpose: shared constants, command set and decode for the LCD command decoder
// Assumes: one 40 MHz clock, AHB-Lite word registers
// Notes:   byte addresses of the register window are listed here only
package lcd_cmd_pkg;

  // ==========================================================
  // register window (byte addresses)
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_DATA   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SETUP  = 8'h0C;

  // status field positions
  localparam int STS_BUSY    = 0;
  localparam int STS_STANDBY = 1;
  localparam int STS_PTR     = 8;
  localparam int STS_COUNT   = 16;
  localparam int STS_STAGE   = 20;

  // setup readback field positions
  localparam int SET_OPTION  = 0;
  localparam int SET_DIVIDER = 2;
  localparam int SET_BANK    = 4;
  localparam int SET_SOE     = 5;
  localparam int SET_DISPLAY_SWITCH_CMD    = 6;
  localparam int SET_ICONS   = 7;
  localparam int SET_DOTBLK  = 8;
  localparam int SET_STYLE   = 9;
  localparam int SET_ICONROW = 10;

  // ==========================================================
  // values and counts
  localparam logic [7:0] BLANK_CODE      = 8'h20;
  localparam logic [5:0] PTR_RESET       = 6'h00;
  localparam logic [3:0] PTR_ROW_LAST    = 4'hB;
  localparam logic [3:0] BUSY_SRC_CYCLES = 4'hA;
  localparam logic [2:0] CONTRAST_MAX    = 3'h7;

  // ==========================================================
  // decoded commands
  typedef enum logic [3:0] {
    CMD_NONE, CMD_LOAD_PTR, CMD_OPTION, CMD_DIVIDER, CMD_BANK,
    CMD_CONTRAST, CMD_STANDBY, CMD_SERIAL_OUT, CMD_DISPLAY,
    CMD_ADVANCE, CMD_DOT_BLINK, CMD_GLYPH_BLINK, CMD_BLINK_STYLE,
    CMD_ICON_ROW
  } cmd_t;

  // bit patterns not listed decode to no operation
  function automatic cmd_t decode_cmd(input logic [7:0] b);
    cmd_t c;
    c = CMD_NONE;
    casez (b)
      8'b11??????: c = CMD_LOAD_PTR;
      8'b1011????: c = CMD_OPTION;
      8'b1010????: c = CMD_DIVIDER;
      8'b100?000?: c = CMD_BANK;
      8'b100?001?: c = CMD_CONTRAST;
      8'b100?0100: c = CMD_STANDBY;
      8'b100?011?: c = CMD_SERIAL_OUT;
      8'b100?100?: c = CMD_DISPLAY;
      8'b100?101?: c = CMD_ADVANCE;
      8'b100?110?: c = CMD_DOT_BLINK;
      8'b100?111?: c = CMD_BLINK_STYLE;
      8'b000?00??: c = CMD_GLYPH_BLINK;
      8'b011?????: c = CMD_ICON_ROW;
      default:     c = CMD_NONE;
    endcase
    return c;
  endfunction

endpackage

//--- logic/contrast_counter.sv
// Purpose: 3-bit wrapping contrast counter with pin-selected stage offset
// Assumes: range pins already synchronised by the caller
// Notes:   the counter itself resets to zero, so the stage starts at the range minimum
`timescale 1ns/10ps
`default_nettype none
module contrast_counter
  import lcd_cmd_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       step_i,
  input  wire logic       up_i,
  input  wire logic [1:0] range_i,
  output logic      [2:0] count_o,
  output logic      [3:0] stage_o
);

  // ==========================================================
  // counter, natural 3-bit wrap both ways
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= 3'h0;
    end else if (step_i) begin
      count_o <= up_i ? count_o + 3'h1 : count_o - 3'h1;
    end
  end

  // stage is count plus range offset, so reset lands on the range minimum
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_o <= 4'h0;
    end else begin
      stage_o <= {1'b0, count_o} + {2'b00, range_i};
    end
  end

  // ==========================================================
  // checks
  property p_wrap_up;
    @(posedge clk_i) disable iff (!rst_n_i)
      step_i && up_i && count_o == CONTRAST_MAX |=> count_o == 3'h0;
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("contrast did not wrap up");

  property p_wrap_down;
    @(posedge clk_i) disable iff (!rst_n_i)
      step_i && !up_i && count_o == 3'h0 |=> count_o == CONTRAST_MAX;
  endproperty
  a_wrap_down: assert property (p_wrap_down) else $error("contrast did not wrap down");

endmodule
`default_nettype wire

//--- logic/lcd_command_decoder.sv
// Purpose: command and data byte interpreter of a character/icon LCD controller
// Assumes: AHB-Lite single-word transfers, one clock, pins synchronised here
// Notes:   display memory is never reset; bytes are written to CMD or DATA
// How it works
// - command 11xxxxxx loads its low six bits into the pointer.
// - pointer loads into unused ranges xCH-xFH store 00H instead.
// - option command stores two bits: blank fill, blink cancel, both or none.
// - advance applies the option to the old location, then steps the pointer.
// - divider command sets source clock to input over 1/2/4/8 when external.
// - bank command, only in 1/9 duty, picks character locations 0-11 or 16-27.
// - commands and data reach any location whatever the bank.
// - contrast command steps a 3-bit counter up or down with wrap.
// - range pins offset the contrast stage; reset starts at the minimum.
// - standby command stops the oscillator and drives outputs to supply high.
// - in standby any byte with bit 0 set wakes and is executed.
// - serial output control, serial mode only: bit 0 enables, else high-z.
// - display command: off drives supply high, on shows icons or both.
// - pointer walks 0-11, 16-27, 32-43, 48-59, then back to 0.
// - dot blink mask mode stores data bytes as per-dot icon blink masks.
// - a blink mask bit on an unlit icon dot shows no blink.
// - host pads icon bytes; mask writes to 0-31 and 44-47 are ignored.
// - glyph blink command sets or clears blink at the pointer from bit 1.
// - blink style picks all-dots-on or all-dots-off alternation.
// - icon row command maps the two icon rows to common lines per duty.
// - pointer advances after data bytes, mask bytes, advance and glyph blink.
// - reset clears pointer and settings and leaves standby off.
// - each executed byte write except standby is busy for ten source cycles; the host must wait.
// - reset does not clear display memory.
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module lcd_command_decoder
  import lcd_cmd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        osc_source_select_i,
  input  wire logic        serial_mode_i,
  input  wire logic        duty_1_9_i,
  input  wire logic        contrast_range_pin_a_i,
  input  wire logic        contrast_range_pin_b_i,
  input  wire logic [5:0]  scan_addr_i,
  output logic      [7:0]  scan_code_o,
  output logic             scan_glyph_blink_o,
  output logic      [4:0]  scan_icon_blink_o,
  output logic             scan_visible_o,
  output logic             osc_run_o,
  output logic             outputs_high_o,
  output logic             blink_style_o,
  output logic             source_tick_o,
  output logic             serial_out_oe_n_o,
  output logic      [3:0]  contrast_stage_o,
  output logic      [4:0]  icon1_line_o,
  output logic      [4:0]  icon2_line_o,
  output logic      [4:0]  glyph_first_line_o
);

  // ==========================================================
  // helpers
  function automatic logic is_icon(input logic [5:0] a);
    return a[5] && (a[3:2] != 2'b11);
  endfunction

  function automatic logic [5:0] ptr_step(input logic [5:0] a);
    if (a[3:0] == PTR_ROW_LAST) begin
      return {a[5:4] + 2'b01, 4'h0};
    end
    return a + 6'h01;
  endfunction

  // ==========================================================
  // pin synchronisers: only the second stage is read
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else begin
      pin_meta <= {contrast_range_pin_b_i, contrast_range_pin_a_i,
                   duty_1_9_i, serial_mode_i, osc_source_select_i};
      pin_sync <= pin_meta;
    end
  end
  logic osc_sel;
  logic serial_mode;
  logic duty9;
  assign osc_sel     = pin_sync[0];
  assign serial_mode = pin_sync[1];
  assign duty9       = pin_sync[2];

  // ==========================================================
  // state
  logic [5:0] ptr;
  logic [1:0] option;
  logic [1:0] divider;
  logic       bank;
  logic       soe;
  logic       display_switch_cmd_on;
  logic       icons_only;
  logic       dot_blink;
  logic       style;
  logic [1:0] icon_row;
  logic       standby;
  logic [3:0] busy_cnt;
  logic [2:0] prescale;
  logic [2:0] count;
  logic       busy;
  logic       tick;
  logic [2:0] div_mask;

  // display memory, deliberately without reset
  logic [7:0] code_mem  [64];
  logic       gblink_mem[64];
  logic [4:0] imask_mem [64];

  // ==========================================================
  // AHB-Lite slave
  logic       dp_act;
  logic       dp_wr;
  logic [7:0] dp_addr;
  logic       take;
  logic       byte_wr;
  logic       is_cmd;
  logic       exec;
  logic       run;
  logic [7:0] b;
  cmd_t       cmd;
  logic       data_wr;
  logic       ptr_adv;
  logic [5:0] ptr_inc;
  logic [5:0] load_val;

  assign take    = hsel_i && htrans_i[1] && hready_i;
  assign is_cmd  = dp_addr == OFS_CMD;
  assign byte_wr = dp_act && dp_wr && (is_cmd || dp_addr == OFS_DATA);
  // a byte write waits in its data phase until the previous one is done
  assign hreadyout_o = !(byte_wr && busy);
  assign hresp_o     = 1'b0;
  assign b       = hwdata_i[7:0];
  assign exec    = byte_wr && !busy;
  // in standby only bytes with bit 0 set get through
  assign run     = exec && (!standby || b[0]);
  assign cmd     = (run && is_cmd) ? decode_cmd(b) : CMD_NONE;
  assign data_wr = run && !is_cmd;
  assign ptr_adv = data_wr || cmd == CMD_ADVANCE || cmd == CMD_GLYPH_BLINK;
  assign ptr_inc = ptr_step(ptr);
  assign load_val = (b[3:2] == 2'b11) ? PTR_RESET : b[5:0];

  // address phase capture; hsize is ignored, every access is a word
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dp_act  <= 1'b0;
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready_i) begin
      dp_act  <= take;
      dp_wr   <= hwrite_i;
      dp_addr <= haddr_i[7:0];
    end
  end

  // read data sampled at the address phase; unmapped reads give zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (take && !hwrite_i) begin
      hrdata_o <= 32'h0000_0000;
      case (haddr_i[7:0])
        OFS_DATA: hrdata_o[7:0] <= code_mem[ptr];
        OFS_STATUS: begin
          hrdata_o[STS_BUSY]          <= busy;
          hrdata_o[STS_STANDBY]       <= standby;
          hrdata_o[STS_PTR+:6]        <= ptr;
          hrdata_o[STS_COUNT+:3]      <= count;
          hrdata_o[STS_STAGE+:4]      <= contrast_stage_o;
        end
        OFS_SETUP: begin
          hrdata_o[SET_OPTION+:2]     <= option;
          hrdata_o[SET_DIVIDER+:2]    <= divider;
          hrdata_o[SET_BANK]          <= bank;
          hrdata_o[SET_SOE]           <= soe;
          hrdata_o[SET_DISPLAY_SWITCH_CMD]          <= display_switch_cmd_on;
          hrdata_o[SET_ICONS]         <= icons_only;
          hrdata_o[SET_DOTBLK]        <= dot_blink;
          hrdata_o[SET_STYLE]         <= style;
          hrdata_o[SET_ICONROW+:2]    <= icon_row;
        end
        default: hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // source clock: divider only applies to an external clock
  always_comb begin
    case (osc_sel ? 2'b00 : divider)
      2'b01:   div_mask = 3'h1;
      2'b10:   div_mask = 3'h3;
      2'b11:   div_mask = 3'h7;
      default: div_mask = 3'h0;
    endcase
  end
  // the oscillator is stopped in standby, so no ticks then
  assign tick = !standby && ((prescale & div_mask) == div_mask);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescale <= 3'h0;
    end else if (!standby) begin
      prescale <= prescale + 3'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      source_tick_o <= 1'b0;
    end else begin
      source_tick_o <= tick;
    end
  end

  // busy counts source cycles; standby entry drops it as nothing is pending
  assign busy = busy_cnt != 4'h0;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_cnt <= 4'h0;
    end else if (cmd == CMD_STANDBY) begin
      busy_cnt <= 4'h0;
    end else if (run) begin
      busy_cnt <= BUSY_SRC_CYCLES;
    end else if (tick && busy) begin
      busy_cnt <= busy_cnt - 4'h1;
    end
  end

  // ==========================================================
  // standby
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      standby <= 1'b0;
    end else if (run && standby) begin
      standby <= 1'b0;
    end else if (cmd == CMD_STANDBY) begin
      standby <= 1'b1;
    end
  end

  // ==========================================================
  // address pointer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr <= PTR_RESET;
    end else if (cmd == CMD_STANDBY) begin
      ptr <= PTR_RESET;
    end else if (cmd == CMD_LOAD_PTR) begin
      ptr <= load_val;
    end else if (ptr_adv) begin
      ptr <= ptr_inc;
    end
  end

  // ==========================================================
  // settings
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      option     <= 2'b00;
      divider    <= 2'b00;
      bank       <= 1'b0;
      soe        <= 1'b0;
      display_switch_cmd_on    <= 1'b0;
      icons_only <= 1'b0;
      dot_blink  <= 1'b0;
      style      <= 1'b0;
      icon_row   <= 2'b00;
    end else begin
      case (cmd)
        CMD_OPTION:      option <= b[1:0];
        CMD_DIVIDER:     divider <= b[1:0];
        CMD_BANK:        if (duty9) bank <= b[0];
        CMD_SERIAL_OUT:  if (serial_mode) soe <= b[0];
        CMD_DISPLAY: begin
          display_switch_cmd_on    <= b[0];
          icons_only <= b[4];
        end
        CMD_DOT_BLINK:   dot_blink <= b[0];
        CMD_BLINK_STYLE: style <= b[0];
        CMD_ICON_ROW:    icon_row <= b[1:0];
        default:         option <= option;
      endcase
    end
  end

  contrast_counter u_contrast (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .step_i  (cmd == CMD_CONTRAST),
    .up_i    (b[0]),
    .range_i (pin_sync[4:3]),
    .count_o (count),
    .stage_o (contrast_stage_o)
  );

  // ==========================================================
  // display memory writes; any location, bank does not matter
  always_ff @(posedge clk_i) begin
    if (data_wr && !dot_blink) begin
      code_mem[ptr] <= b;
    end else if (cmd == CMD_ADVANCE && option[0]) begin
      code_mem[ptr] <= BLANK_CODE;
    end
    if (cmd == CMD_GLYPH_BLINK) begin
      gblink_mem[ptr] <= b[1];
    end else if (cmd == CMD_ADVANCE && option[1]) begin
      gblink_mem[ptr] <= 1'b0;
    end
    // mask bytes to non-icon locations are dropped; top bits are padding
    if (data_wr && dot_blink && is_icon(ptr)) begin
      imask_mem[ptr] <= b[4:0];
    end
  end

  // ==========================================================
  // scan port for the waveform side
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scan_code_o        <= 8'h00;
      scan_glyph_blink_o <= 1'b0;
      scan_icon_blink_o  <= 5'h00;
      scan_visible_o     <= 1'b0;
    end else begin
      scan_code_o        <= code_mem[scan_addr_i];
      scan_glyph_blink_o <= gblink_mem[scan_addr_i] && !is_icon(scan_addr_i);
      // a mask on an unlit dot has nothing to blink
      scan_icon_blink_o  <= is_icon(scan_addr_i) ?
                            imask_mem[scan_addr_i] & code_mem[scan_addr_i][4:0] : 5'h00;
      scan_visible_o     <= display_switch_cmd_on && !standby && (is_icon(scan_addr_i) ||
                            (!icons_only && (!duty9 || scan_addr_i[4] == bank)));
    end
  end

  // ==========================================================
  // drive-level outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_run_o         <= 1'b1;
      outputs_high_o    <= 1'b1;
      blink_style_o     <= 1'b0;
      serial_out_oe_n_o <= 1'b1;
    end else begin
      osc_run_o         <= !standby;
      outputs_high_o    <= standby || !display_switch_cmd_on;
      blink_style_o     <= style;
      serial_out_oe_n_o <= !(serial_mode && soe);
    end
  end

  // icon row to common line map; character rows follow the same choice
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      icon1_line_o       <= 5'h01;
      icon2_line_o       <= 5'h02;
      glyph_first_line_o <= 5'h03;
    end else begin
      casez (icon_row)
        2'b00: begin
          icon1_line_o       <= 5'h01;
          icon2_line_o       <= 5'h02;
          glyph_first_line_o <= 5'h03;
        end
        2'b01: begin
          icon1_line_o       <= duty9 ? 5'h08 : 5'h0F;
          icon2_line_o       <= duty9 ? 5'h09 : 5'h10;
          glyph_first_line_o <= 5'h01;
        end
        default: begin
          icon1_line_o       <= duty9 ? 5'h09 : 5'h10;
          icon2_line_o       <= 5'h01;
          glyph_first_line_o <= 5'h02;
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_ptr_legal;
    ptr[3:2] != 2'b11;
  endproperty
  a_ptr_legal: assert property (p_ptr_legal) else $error("pointer in unused range");

  property p_ptr_load;
    cmd == CMD_LOAD_PTR |=> ptr == $past(load_val);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer load wrong");

  property p_ptr_step;
    ptr_adv && cmd != CMD_LOAD_PTR |=> ptr == $past(ptr_inc) && ptr[3:0] <= PTR_ROW_LAST;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer step wrong");

  property p_busy_stall;
    byte_wr && busy |-> !hreadyout_o ##1 (ptr == $past(ptr) && standby == $past(standby));
  endproperty
  a_busy_stall: assert property (p_busy_stall) else $error("write accepted while busy");

  property p_busy_len;
    run && cmd != CMD_STANDBY && cmd != CMD_DIVIDER && div_mask == 3'h0 && !standby
      |=> busy [*8] ##1 busy ##1 busy ##1 !busy;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length not ten");

  property p_wake;
    standby && exec && b[0] |=> !standby;
  endproperty
  a_wake: assert property (p_wake) else $error("standby not left");

  property p_stay_asleep;
    standby && exec && !b[0] |=> standby && ptr == $past(ptr);
  endproperty
  a_stay_asleep: assert property (p_stay_asleep) else $error("byte ran in standby");

  property p_sleep_outputs;
    cmd == CMD_STANDBY |=> ##1 !osc_run_o && outputs_high_o && !tick;
  endproperty
  a_sleep_outputs: assert property (p_sleep_outputs) else $error("standby outputs wrong");

  property p_display_switch_cmd_off;
    cmd == CMD_DISPLAY && !b[0] |=> ##1 outputs_high_o;
  endproperty
  a_display_switch_cmd_off: assert property (p_display_switch_cmd_off) else $error("display off not high");

  property p_so_off;
    cmd == CMD_SERIAL_OUT && !b[0] && serial_mode |=> ##1 serial_out_oe_n_o;
  endproperty
  a_so_off: assert property (p_so_off) else $error("serial out not released");

  c_wake: cover property (standby && run);
  c_wrap: cover property (ptr == 6'h3B && ptr_adv);
  c_stall: cover property (byte_wr && busy);

endmodule
`default_nettype wire

//--- verif/strap_model.sv
// Purpose: board strap pins seen by the decoder (far-side levels)
// Assumes: levels change only between tests
// Notes:   re-timed here so a level never moves on the sampling edge
`timescale 1ns/10ps
`default_nettype none
module strap_model (
  input  wire logic       clk_i,
  input  wire logic [4:0] want_i,
  output logic      [4:0] pins_o
);
  // ========================================
  // launch the requested levels just after an edge
  always_ff @(posedge clk_i) begin
    pins_o <= want_i;
  end
endmodule
`default_nettype wire

//--- verif/tb.sv
// Purpose: self-checking bench for the LCD command decoder
// Assumes: internal oscillator strap except in the divider test
// Notes:   bus tasks wait on hready; only the timeout ends a wait
`timescale 1ns/10ps
`default_nettype none
module tb;
  import lcd_cmd_pkg::*;
  logic        clk_i = 0;
  logic        rst_n_i = 0;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic        hready;
  logic [4:0]  want = 5'h09;
  logic [4:0]  pins;
  logic [31:0] rd;
  logic        osc_run, out_high, oe_n;
  logic [3:0]  stage;
  logic [4:0]  icon1, icon2, glyph1, s_iblink;
  logic [7:0]  s_code;
  logic [5:0]  scan = 6'h00;
  logic        s_gblink, s_vis, style_o, src_tick;
  int          ticks = 0;
  int          n;
  int          bad_count = 0;
  int          checks_done = 0;
  int          cycles = 0;

  always #12.5 clk_i = ~clk_i;

  // ========================================
  // device and straps
  strap_model strap_u (.clk_i(clk_i), .want_i(want), .pins_o(pins));
  lcd_command_decoder dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
    .osc_source_select_i(pins[0]), .serial_mode_i(pins[1]), .duty_1_9_i(pins[2]),
    .contrast_range_pin_a_i(pins[3]), .contrast_range_pin_b_i(pins[4]),
    .scan_addr_i(scan), .scan_code_o(s_code), .scan_glyph_blink_o(s_gblink), .scan_icon_blink_o(s_iblink),
    .scan_visible_o(s_vis), .osc_run_o(osc_run), .outputs_high_o(out_high),
    .blink_style_o(style_o), .source_tick_o(src_tick), .serial_out_oe_n_o(oe_n),
    .contrast_stage_o(stage), .icon1_line_o(icon1), .icon2_line_o(icon2),
    .glyph_first_line_o(glyph1)
  );

  // ========================================
  // reporting
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard: the whole sequence needs well under this many clocks
  always @(posedge clk_i) begin
    cycles++;
    // source ticks counted off the edge so a snapshot never races the count
    if (src_tick === 1'b1) ticks <= ticks + 1;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ========================================
  // bus tasks: address phase, then data phase held until hready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
    hwrite <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic cmd(input logic [7:0] b);
    xfer(1'b1, OFS_CMD, {24'h0, b});
  endtask

  task automatic rdst;
    xfer(1'b0, OFS_STATUS, '0);
  endtask

  task automatic rdset;
    xfer(1'b0, OFS_SETUP, '0);
  endtask

  // ========================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdset();
    chk("setup", rd, '0);
    rdst();
    chk("status", rd & 32'h0000_3F02, '0);
    chk("stage", {28'h0, stage}, 32'h1);
    chk("lines", {icon1, icon2, glyph1}, {5'd1, 5'd2, 5'd3});
    chk("oe_n", {31'h0, oe_n}, 32'h1);
    cmd(8'h84 ^ 8'h4F);
    rdst();
    chk("busy", {31'h0, rd[STS_BUSY]}, 32'h1);
    chk("ptr", {26'h0, rd[13:8]}, 32'h0B);
    cmd(8'hCC);
    rdst();
    chk("ptr", {26'h0, rd[13:8]}, 32'h00);
    cmd(8'hCB);
    xfer(1'b1, OFS_DATA, 32'h41);
    rdst();
    chk("ptr", {26'h0, rd[13:8]}, 32'h10);
    cmd(8'hFB);
    cmd(8'h9A);
    rdst();
    chk("ptr", {26'h0, rd[13:8]}, 32'h00);
    cmd(8'hC5);
    xfer(1'b1, OFS_DATA, 32'h41);
    cmd(8'hC5);
    xfer(1'b0, OFS_DATA, '0);
    chk("data", rd, 32'h41);
    cmd(8'hB1);
    cmd(8'h9A);
    rdst();
    chk("ptr", {26'h0, rd[13:8]}, 32'h06);
    cmd(8'hC5);
    xfer(1'b0, OFS_DATA, '0);
    chk("data", rd, {24'h0, BLANK_CODE});
    cmd(8'h82);
    repeat (3) @(posedge clk_i);
    rdst();
    chk("count", {29'h0, rd[18:16]}, 32'h7);
    chk("stage", {28'h0, stage}, 32'h8);
    cmd(8'h83);
    rdst();
    chk("count", {29'h0, rd[18:16]}, 32'h0);
    cmd(8'h81);
    rdset();
    chk("bank", {31'h0, rd[SET_BANK]}, 32'h0);
    want <= 5'h08;
    repeat (4) @(posedge clk_i);
    cmd(8'hA1);
    @(posedge clk_i);
    n = ticks;
    repeat (16) @(posedge clk_i);
    chk("ticks", ticks - n, 32'd8);
    cmd(8'hA0);
    want <= 5'h0F;
    repeat (4) @(posedge clk_i);
    cmd(8'h81);
    cmd(8'h87);
    rdset();
    chk("bank", {31'h0, rd[SET_BANK]}, 32'h1);
    chk("oe_n", {31'h0, oe_n}, 32'h0);
    want <= 5'h09;
    repeat (4) @(posedge clk_i);
    cmd(8'h61);
    @(posedge clk_i);
    chk("lines", {icon1, icon2, glyph1}, {5'd15, 5'd16, 5'd1});
    cmd(8'h62);
    @(posedge clk_i);
    chk("lines", {icon1, icon2, glyph1}, {5'd16, 5'd1, 5'd2});
    cmd(8'h84);
    repeat (2) @(posedge clk_i);
    rdst();
    chk("standby", {30'h0, rd[1:0]}, 32'h2);
    chk("pins", {30'h0, osc_run, out_high}, 32'h1);
    xfer(1'b1, OFS_DATA, 32'h02);
    rdst();
    chk("standby", {31'h0, rd[STS_STANDBY]}, 32'h1);
    cmd(8'h99);
    repeat (2) @(posedge clk_i);
    rdset();
    chk("display_switch_cmd", {30'h0, rd[7:6]}, 32'h3);
    chk("pins", {30'h0, osc_run, out_high}, 32'h2);
    cmd(8'hE0);
    xfer(1'b1, OFS_DATA, 32'hE5);
    cmd(8'h8D);
    cmd(8'hE0);
    xfer(1'b1, OFS_DATA, 32'hE3);
    cmd(8'h8C);
    scan <= 6'h20;
    repeat (2) @(posedge clk_i);
    chk("icon_blink", {27'h0, s_iblink}, 32'h01);
    chk("visible", {31'h0, s_vis}, 32'h1);
    cmd(8'hC5);
    xfer(1'b1, OFS_DATA, 32'h41);
    cmd(8'hC5);
    cmd(8'h02);
    scan <= 6'h05;
    repeat (2) @(posedge clk_i);
    chk("gblink", {31'h0, s_gblink}, 32'h1);
    chk("visible", {31'h0, s_vis}, 32'h0);
    cmd(8'hB2);
    cmd(8'hC5);
    cmd(8'h9A);
    @(posedge clk_i);
    chk("gblink", {31'h0, s_gblink}, 32'h0);
    chk("code", {24'h0, s_code}, 32'h41);
    cmd(8'h9F);
    @(posedge clk_i);
    chk("style", {31'h0, style_o}, 32'h1);
    xfer(1'b0, 8'h10, '0);
    chk("unmapped", rd, '0);
    give_verdict();
  end
endmodule
`default_nettype wire
